/* File: clkbuf_smbus_target.sv */
// Serial bus target and loop control outputs of the clock buffer
//
// How it works
// - Answer target address d4 write, d5 read.
// - Bit 7 set: bandwidth follows pin, loop stays engaged; resets one.
// - Bit 1 picks high or low bandwidth.
// - Bit 0 clear bypasses loop; default engaged.
// - Reserved bytes are storage with no function.
// - Byte three returns revision and maker nibbles.
// - Byte four returns fixed device code, read-only.
// - Byte five sets read count, resets six.
// - Block write: index, count, data; all acknowledged.
// - Block read: count then data from index.
`timescale 1ns/1ps
`default_nettype none
module clkbuf_smbus_target
  import clkbuf_regs_pkg::*;
#(
  // Identification values are arbitrary
  parameter logic [3:0] REVISION_CODE = 4'h2,
  parameter logic [3:0] MAKER_CODE = 4'h5,
  parameter logic [7:0] DEVICE_CODE = 8'h3c
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Serial bus pins, data is open drain
  input wire logic smb_clk,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe_n,
  // Loop control
  input wire logic bandwidth_pin,
  output logic loop_bandwidth_select,
  output logic loop_engage
);

  logic [1:0] clk_sync;
  logic [1:0] data_sync;
  logic [1:0] bw_sync;
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  bus_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] byte_num;
  logic [7:0] index;
  logic reading;
  logic send_count;
  logic ack_this;
  logic host_nack;
  logic wr_en;
  logic [7:0] rd_data;
  logic [7:0] loop_control;
  logic [7:0] readback_count;

  // Pins are asynchronous, two flops before use
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clk_sync <= 2'b11;
      data_sync <= 2'b11;
      // Idle at high bandwidth so pin mode shows no dip after reset
      bw_sync <= 2'b11;
    end else begin
      clk_sync <= {clk_sync[0], smb_clk};
      data_sync <= {data_sync[0], smb_data_in};
      bw_sync <= {bw_sync[0], bandwidth_pin};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= clk_sync[1];
      sda_prev <= data_sync[1];
    end
  end

  assign scl_rise = clk_sync[1] && !scl_prev;
  assign scl_fall = !clk_sync[1] && scl_prev;
  // Data moving while the clock is high marks start or stop
  assign start_seen = clk_sync[1] && scl_prev && sda_prev && !data_sync[1];
  assign stop_seen = clk_sync[1] && scl_prev && !sda_prev && data_sync[1];

  // Write strobe on the last bit of a data byte of a write
  assign wr_en = (state == ST_RX) && scl_fall && (bit_cnt == BITS_PER_BYTE) &&
                 (byte_num > BYTE_NUM_COUNT);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      byte_num <= 8'h00;
      index <= 8'h00;
      reading <= 1'b0;
      send_count <= 1'b0;
      ack_this <= 1'b0;
      host_nack <= 1'b0;
    end else if (start_seen) begin
      // Repeated start keeps the index for the read that follows
      state <= ST_RX;
      bit_cnt <= 4'h0;
      byte_num <= BYTE_NUM_ADDR;
      reading <= 1'b0;
    end else if (stop_seen) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          bit_cnt <= 4'h0;
        end
        ST_RX: begin
          if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
            shift <= {shift[6:0], data_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            state <= ST_RX_ACK;
            ack_this <= 1'b1;
            if (byte_num == BYTE_NUM_ADDR) begin
              if (shift[7:1] == TARGET_ADDR) begin
                reading <= shift[0];
                send_count <= shift[0];
              end else begin
                ack_this <= 1'b0;
                state <= ST_IDLE;
              end
            end else if (byte_num == BYTE_NUM_INDEX) begin
              index <= shift;
            end else if (byte_num > BYTE_NUM_COUNT) begin
              index <= index + 8'h01;
            end
            if (byte_num != 8'hff) begin
              byte_num <= byte_num + 8'h01;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            ack_this <= 1'b0;
            if (reading) begin
              state <= ST_TX;
              shift <= readback_count;
            end else begin
              state <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
              bit_cnt <= 4'h0;
              state <= ST_TX_ACK;
              if (!send_count) begin
                index <= index + 8'h01;
              end
              send_count <= 1'b0;
            end else begin
              shift <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            host_nack <= data_sync[1];
          end else if (scl_fall) begin
            // Not-acknowledge ends the read
            if (host_nack) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_TX;
              shift <= rd_data;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pull low
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      smb_data_out <= 1'b0;
      smb_data_oe_n <= 1'b1;
    end else begin
      smb_data_out <= 1'b0;
      case (state)
        ST_RX_ACK: smb_data_oe_n <= !ack_this;
        ST_TX: smb_data_oe_n <= shift[7];
        default: smb_data_oe_n <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      loop_bandwidth_select <= 1'b1;
      loop_engage <= 1'b1;
    end else if (loop_control[REGISTER_OVERRIDE_SELECT_BIT]) begin
      // No bypass pin exists, so pin mode keeps the loop engaged
      loop_bandwidth_select <= bw_sync[1];
      loop_engage <= 1'b1;
    end else begin
      loop_bandwidth_select <= loop_control[LOOP_BANDWIDTH_SELECT_BIT];
      loop_engage <= loop_control[LOOP_ENGAGE_BIT];
    end
  end

  clkbuf_reg_bank #(
    .REVISION_CODE(REVISION_CODE),
    .MAKER_CODE(MAKER_CODE),
    .DEVICE_CODE(DEVICE_CODE)
  ) u_bank (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr_en(wr_en),
    .wr_idx(index),
    .wr_data(shift),
    .rd_idx(index),
    .rd_data(rd_data),
    .loop_control(loop_control),
    .readback_count(readback_count)
  );

endmodule : clkbuf_smbus_target
`default_nettype wire

/* File: clkbuf_regs_pkg.sv */
// Shared constants for the serial register bank of the clock buffer
package clkbuf_regs_pkg;

  // Target address: write form d4, read form d5
  localparam logic [6:0] TARGET_ADDR = 7'h6a;
  localparam logic [7:0] TARGET_ADDR_WRITE = 8'hd4;
  localparam logic [7:0] TARGET_ADDR_READ = 8'hd5;

  // Register indices
  localparam logic [7:0] IDX_LOOP_CONTROL = 8'h00;
  localparam logic [7:0] IDX_OUTPUT_ENABLE_RESERVED = 8'h01;
  localparam logic [7:0] IDX_FUNCTION_SELECT_RESERVED = 8'h02;
  localparam logic [7:0] IDX_VENDOR_REVISION_ID = 8'h03;
  localparam logic [7:0] IDX_DEVICE_ID = 8'h04;
  localparam logic [7:0] IDX_READBACK_COUNT = 8'h05;
  localparam int NUM_REGS = 6;

  // Field positions in loop_control
  localparam int REGISTER_OVERRIDE_SELECT_BIT = 7;
  localparam int LOOP_BANDWIDTH_SELECT_BIT = 1;
  localparam int LOOP_ENGAGE_BIT = 0;

  // Values after reset
  localparam logic [7:0] LOOP_CONTROL_RESET = 8'h83;
  localparam logic [7:0] RESERVED_RESET = 8'h00;
  localparam logic [7:0] READBACK_COUNT_RESET = 8'h06;

  // Bus phase counts
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] BYTE_NUM_ADDR = 8'h00;
  localparam logic [7:0] BYTE_NUM_INDEX = 8'h01;
  localparam logic [7:0] BYTE_NUM_COUNT = 8'h02;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TX_ACK = 3'b100
  } bus_state_t;

  // Bytes that a write may change; identification bytes are read-only
  function automatic logic is_writable(input logic [7:0] idx);
    is_writable = (idx == IDX_LOOP_CONTROL) || (idx == IDX_OUTPUT_ENABLE_RESERVED) ||
                  (idx == IDX_FUNCTION_SELECT_RESERVED) || (idx == IDX_READBACK_COUNT);
  endfunction : is_writable

endpackage : clkbuf_regs_pkg

/* File: clkbuf_reg_bank.sv */
// Byte-wide register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module clkbuf_reg_bank
  import clkbuf_regs_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE = 4'h2,
  parameter logic [3:0] MAKER_CODE = 4'h5,
  parameter logic [7:0] DEVICE_CODE = 8'h3c
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Read side
  input wire logic [7:0] rd_idx,
  output logic [7:0] rd_data,
  // Fields used by the block
  output logic [7:0] loop_control,
  output logic [7:0] readback_count
);

  logic [7:0] output_enable_reserved;
  logic [7:0] function_select_reserved;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      loop_control <= LOOP_CONTROL_RESET;
      output_enable_reserved <= RESERVED_RESET;
      function_select_reserved <= RESERVED_RESET;
      readback_count <= READBACK_COUNT_RESET;
    end else if (wr_en && is_writable(wr_idx)) begin
      case (wr_idx)
        IDX_LOOP_CONTROL: loop_control <= wr_data;
        IDX_OUTPUT_ENABLE_RESERVED: output_enable_reserved <= wr_data;
        IDX_FUNCTION_SELECT_RESERVED: function_select_reserved <= wr_data;
        IDX_READBACK_COUNT: readback_count <= wr_data;
        default: loop_control <= loop_control;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else begin
      case (rd_idx)
        IDX_LOOP_CONTROL: rd_data <= loop_control;
        IDX_OUTPUT_ENABLE_RESERVED: rd_data <= output_enable_reserved;
        IDX_FUNCTION_SELECT_RESERVED: rd_data <= function_select_reserved;
        IDX_VENDOR_REVISION_ID: rd_data <= {REVISION_CODE, MAKER_CODE};
        IDX_DEVICE_ID: rd_data <= DEVICE_CODE;
        IDX_READBACK_COUNT: rd_data <= readback_count;
        default: rd_data <= 8'h00;
      endcase
    end
  end

endmodule : clkbuf_reg_bank
`default_nettype wire

/* File: clkbuf_regs_checker_assertions.sv */
// Port-level checks of the serial register bank
`timescale 1ns/1ps
`default_nettype none
module clkbuf_regs_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus and loop pins
  input wire logic smb_clk,
  input wire logic smb_data_out,
  input wire logic smb_data_oe_n,
  input wire logic loop_bandwidth_select,
  input wire logic loop_engage
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_quiet; $rose(rstn) |-> smb_data_oe_n[*4]; endproperty
  a_quiet: assert property (p_quiet) else $error("data pin driven after reset");
  property p_rst_bw; $rose(rstn) |-> loop_bandwidth_select; endproperty
  a_rst_bw: assert property (p_rst_bw) else $error("bandwidth not high after reset");
  property p_rst_eng; $rose(rstn) |-> loop_engage; endproperty
  a_rst_eng: assert property (p_rst_eng) else $error("loop not engaged after reset");
  property p_dout; smb_data_out == 1'b0; endproperty
  a_dout: assert property (p_dout) else $error("data pin drives high");
  property p_scl_high; smb_clk && $past(smb_clk) |-> $stable(smb_data_oe_n); endproperty
  a_scl_high: assert property (p_scl_high) else $error("data moved while clock high");
  property p_ack_hold; $fell(smb_data_oe_n) |-> !smb_data_oe_n[*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low bit too short");
  property p_eng_when; $changed(loop_engage) |-> !smb_clk; endproperty
  a_eng_when: assert property (p_eng_when) else $error("loop changed outside a write");
  // Register mode ignores the pin, so bandwidth moves only on writes
  property p_bw_when; !loop_engage && $changed(loop_bandwidth_select) |-> !smb_clk; endproperty
  a_bw_when: assert property (p_bw_when) else $error("bandwidth followed pin");
  c_ack: cover property ($fell(smb_data_oe_n));
  c_bypass: cover property ($fell(loop_engage));
  c_bw_low: cover property ($fell(loop_bandwidth_select));
endmodule : clkbuf_regs_checker
bind clkbuf_smbus_target clkbuf_regs_checker u_chk (.core_clk, .rstn, .smb_clk, .smb_data_out,
  .smb_data_oe_n, .loop_bandwidth_select, .loop_engage);
`default_nettype wire

/* File: smbus_host_model.sv */
// Behavioural serial bus host
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  // Clock
  input wire logic core_clk,
  // Bus wires, data resolved by the bench
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  int ph = 8;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Raise ph for a slow host; three cycles is the floor
  task automatic half();
    repeat (ph) @(posedge core_clk);
  endtask : half
  // Also serves as repeated start
  task automatic start();
    sda_rel <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask : start
  task automatic stop();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b1;
    half();
  endtask : stop
  // Ninth bit is the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_rel <= tx[i];
      half();
      scl <= 1'b1;
      half();
      rx[i] = sda;
      scl <= 1'b0;
      half();
    end
  endtask : xfer
endmodule : smbus_host_model
`default_nettype wire

/* File: smbus_clock_buffer_regs_bench.sv */
// Self-checking bench of the serial register bank
`timescale 1ns/1ps
`default_nettype none
module smbus_clock_buffer_regs_bench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic bandwidth_pin = 1'b1;
  logic scl, sda_rel, dout, oe_n, bw, eng;
  logic [8:0] rx;
  // Pull-up on the data wire
  wire sda = sda_rel & (oe_n | dout);
  int errors = 0;
  int cmp_count = 0;
  int mdl[256];
  int idx = 0;
  int tbl[6] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h80, 8'hfd};
  always #10 core_clk = ~core_clk;
  smbus_host_model h (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  // Identification values are arbitrary
  clkbuf_smbus_target #(.REVISION_CODE(4'h9), .MAKER_CODE(4'h7), .DEVICE_CODE(8'h5a)) uut (
    .core_clk(core_clk), .rstn(rstn), .smb_clk(scl), .smb_data_in(sda), .smb_data_out(dout),
    .smb_data_oe_n(oe_n), .bandwidth_pin(bandwidth_pin), .loop_bandwidth_select(bw),
    .loop_engage(eng));
  task automatic finish_test();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input int exp);
    cmp_count++;
    if (got !== exp[7:0]) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp[7:0]);
    end
  endtask : chk
  task automatic snd(input int b);
    h.xfer({b[7:0], 1'b1}, rx);
    chk(rx[0], 0);
  endtask : snd
  task automatic wr(input int n, input int q[$]);
    h.start();
    snd(8'hd4);
    snd(n);
    snd(q.size());
    idx = n;
    foreach (q[i]) begin
      snd(q[i]);
      if (idx < 3 || idx == 5) mdl[idx] = q[i];
      idx = (idx + 1) % 256;
    end
    h.stop();
  endtask : wr
  task automatic rd(input int n, input int k);
    h.start();
    snd(8'hd4);
    snd(n);
    idx = n;
    h.start();
    snd(8'hd5);
    h.xfer(9'h1fe, rx);
    chk(rx[8:1], mdl[5]);
    for (int i = 0; i < k; i++) begin
      h.xfer({8'hff, i == k - 1}, rx);
      chk(rx[8:1], mdl[idx]);
      idx = (idx + 1) % 256;
    end
    h.stop();
  endtask : rd
  // Pin mode forces the loop on and passes the pin through
  task automatic lchk();
    repeat (6) @(posedge core_clk);
    chk({bw, eng}, mdl[0][7] ? {bandwidth_pin, 1'b1} : mdl[0] & 3);
  endtask : lchk
  initial begin
    void'($urandom(32'hbbc598e0));
    mdl[0] = 8'h83;
    mdl[3] = 8'h97;
    mdl[4] = 8'h5a;
    mdl[5] = 6;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(0, 6);
    lchk();
    h.start();
    h.xfer({8'hd6, 1'b1}, rx);
    chk(rx[0], 1);
    h.stop();
    foreach (tbl[i]) begin
      bandwidth_pin <= 1'($urandom);
      wr(0, '{tbl[i]});
      lchk();
      bandwidth_pin <= ~bandwidth_pin;
      lchk();
    end
    wr(0, '{0, $urandom % 256, $urandom % 256, 255, 255, 3});
    rd(0, 8);
    // Reset in mid-run must bring every writable byte back to its default
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    mdl[0] = 8'h83;
    mdl[1] = 0;
    mdl[2] = 0;
    mdl[5] = 6;
    rd(0, 6);
    lchk();
    h.ph = 11;
    repeat (6) begin
      wr($urandom % 7, '{$urandom % 256, $urandom % 256});
      rd($urandom % 7, 1 + $urandom % 4);
      lchk();
    end
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    finish_test();
  end
endmodule : smbus_clock_buffer_regs_bench
`default_nettype wire
